/* File: rtl/dram_ap_pkg.sv */
package dram_ap_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_RTP_PS = 7500;
  localparam int T_RP_PB_PS = 18000;
  localparam int T_RP_AB_PS = 21000;
  localparam int T_WR_PS = 15000;

  // least times round up, never below one cycle
  function automatic int ru_cycles(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : ru_cycles

  localparam int RTP_CYC = ru_cycles(T_RTP_PS);
  localparam int RP_PB_CYC = ru_cycles(T_RP_PB_PS);
  localparam int RP_AB_CYC = ru_cycles(T_RP_AB_PS);
  localparam int WR_CYC = ru_cycles(T_WR_PS);

  localparam int NUM_BANKS = 8;
  localparam int CNT_W = 8;
  localparam int DEF_WL = 4;
  localparam int DEF_BL = 8;
  localparam int PREFETCH_WORDS = 4;
  localparam int RTP_LEAD = 2;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_PRE_ALL = 3'h5,
    CMD_BURST_TERM = 3'h6
  } cmd_e;

  typedef enum logic [3:0] {
    BANK_IDLE = 4'h1,
    BANK_ACTIVE = 4'h2,
    BANK_AP_WAIT = 4'h4,
    BANK_PRECHARGING = 4'h8
  } bank_state_e;

  localparam logic [dram_ap_pkg::CNT_W-1:0] CNT_RESET = 8'h00;
endpackage : dram_ap_pkg

/* File: rtl/bank_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface bank_if;
  logic act;
  logic rd;
  logic wr;
  logic ap;
  logic pre;
  logic pre_ab;
  logic [dram_ap_pkg::CNT_W-1:0] rd_ap_delay;
  logic [dram_ap_pkg::CNT_W-1:0] wr_ap_delay;
  dram_ap_pkg::bank_state_e state;
  modport ctrl (output act, rd, wr, ap, pre, pre_ab, rd_ap_delay, wr_ap_delay, input state);
  modport bank (input act, rd, wr, ap, pre, pre_ab, rd_ap_delay, wr_ap_delay, output state);
endinterface : bank_if
`default_nettype wire

/* File: rtl/bank_ap_tracker.sv */
`timescale 1ns/100ps
`default_nettype none
module bank_ap_tracker (
  input wire logic i_core_clk,
  input wire logic i_reset,
  bank_if.bank b
);
  dram_ap_pkg::bank_state_e state_r, state_nxt;
  logic [dram_ap_pkg::CNT_W-1:0] cnt_r, cnt_nxt;

  function automatic logic [dram_ap_pkg::CNT_W-1:0] load(input int cyc);
    return dram_ap_pkg::CNT_W'(cyc - 1);
  endfunction : load

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    // a precharge always restarts the period, whatever the bank was doing
    if (b.pre || b.pre_ab) begin
      state_nxt = dram_ap_pkg::BANK_PRECHARGING;
      cnt_nxt = b.pre_ab ? load(dram_ap_pkg::RP_AB_CYC) : load(dram_ap_pkg::RP_PB_CYC);
    end else begin
      unique case (state_r)
        dram_ap_pkg::BANK_IDLE: begin
          if (b.act) state_nxt = dram_ap_pkg::BANK_ACTIVE;
        end
        dram_ap_pkg::BANK_ACTIVE: begin
          if ((b.rd || b.wr) && b.ap) begin
            state_nxt = dram_ap_pkg::BANK_AP_WAIT;
            cnt_nxt = b.rd ? b.rd_ap_delay - 1'b1 : b.wr_ap_delay - 1'b1;
          end
          // without the bit the row simply stays open
        end
        dram_ap_pkg::BANK_AP_WAIT: begin
          if (cnt_r == '0) begin
            state_nxt = dram_ap_pkg::BANK_PRECHARGING;
            cnt_nxt = load(dram_ap_pkg::RP_PB_CYC);
          end
        end
        dram_ap_pkg::BANK_PRECHARGING: begin
          if (cnt_r == '0) state_nxt = dram_ap_pkg::BANK_IDLE;
        end
        default: state_nxt = dram_ap_pkg::BANK_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= dram_ap_pkg::BANK_IDLE;
      cnt_r <= dram_ap_pkg::CNT_RESET;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign b.state = state_r;
endmodule : bank_ap_tracker
`default_nettype wire

/* File: rtl/dram_auto_precharge_timing.sv */
// Behaviour
// - no auto-precharge bit leaves bank open
// - falling-edge CA0 bit engages auto precharge
// - read precharge starts at max(BL/2, BL/2-2+tRTP)
// - gapless other-bank accesses every BL/2 accepted
// - precharge period timed from latest precharge
// - array write after whole four-word group
// - tRTP starts BL/2-2, truncated uses effective BL (o_eff_burst_len only reports it; RD_AP_CYC always uses the full BL)
`timescale 1ns/100ps
`default_nettype none
module dram_auto_precharge_timing #(
  parameter int WL = dram_ap_pkg::DEF_WL,
  parameter int BL = dram_ap_pkg::DEF_BL
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd,
  input wire logic [2:0] i_bank,
  input wire logic i_ap_bit,
  input wire logic i_wr_word_valid,
  output logic [7:0] o_bank_idle,
  output logic [7:0] o_bank_open,
  output logic [7:0] o_ap_pending,
  output logic [7:0] o_precharging,
  output logic o_array_write,
  output logic [4:0] o_eff_burst_len
);
  localparam int HALF_BL = BL / 2;

  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

  // precharge start after a read or write carrying the bit
  localparam int RD_AP_CYC = max2(HALF_BL, HALF_BL - dram_ap_pkg::RTP_LEAD + dram_ap_pkg::RTP_CYC);
  localparam int WR_AP_CYC = WL + HALF_BL + 1 + dram_ap_pkg::WR_CYC;

  ////////////////////////////////////////////////////////////////////////////
  logic is_act, is_rd, is_wr, is_pre, is_pre_all, is_bst;
  always_comb begin
    is_act = i_cmd_valid && (i_cmd == dram_ap_pkg::CMD_ACT);
    is_rd = i_cmd_valid && (i_cmd == dram_ap_pkg::CMD_RD);
    is_wr = i_cmd_valid && (i_cmd == dram_ap_pkg::CMD_WR);
    is_pre = i_cmd_valid && (i_cmd == dram_ap_pkg::CMD_PRE);
    is_pre_all = i_cmd_valid && (i_cmd == dram_ap_pkg::CMD_PRE_ALL);
    is_bst = i_cmd_valid && (i_cmd == dram_ap_pkg::CMD_BURST_TERM);
  end

  // every bank decodes on its own, so back-to-back commands to other banks just work
  for (genvar g = 0; g < dram_ap_pkg::NUM_BANKS; g++) begin : g_bank
    bank_if bif ();
    logic hit;
    assign hit = (i_bank == 3'(g));
    assign bif.act = is_act && hit;
    assign bif.rd = is_rd && hit;
    assign bif.wr = is_wr && hit;
    assign bif.ap = i_ap_bit;
    assign bif.pre = is_pre && hit;
    assign bif.pre_ab = is_pre_all;
    assign bif.rd_ap_delay = dram_ap_pkg::CNT_W'(RD_AP_CYC);
    assign bif.wr_ap_delay = dram_ap_pkg::CNT_W'(WR_AP_CYC);
    bank_ap_tracker u_bank (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .b(bif.bank)
    );
    // one-hot state bits leave as they are, so every status output is a flop
    assign o_bank_idle[g] = bif.state[0];
    assign o_bank_open[g] = bif.state[1];
    assign o_ap_pending[g] = bif.state[2];
    assign o_precharging[g] = bif.state[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // write data lands in the array only as whole prefetch groups
  logic [1:0] grp_cnt_r, grp_cnt_nxt;
  logic array_write_r, array_write_nxt;
  always_comb begin
    grp_cnt_nxt = grp_cnt_r;
    array_write_nxt = 1'b0;
    if (is_wr) begin
      grp_cnt_nxt = 2'h0;
    end else if (i_wr_word_valid) begin
      grp_cnt_nxt = grp_cnt_r + 2'h1;
      array_write_nxt = (grp_cnt_r == 2'(dram_ap_pkg::PREFETCH_WORDS - 1));
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      grp_cnt_r <= 2'h0;
      array_write_r <= 1'b0;
    end else begin
      grp_cnt_r <= grp_cnt_nxt;
      array_write_r <= array_write_nxt;
    end
  end
  assign o_array_write = array_write_r;

  ////////////////////////////////////////////////////////////////////////////
  // effective burst of the latest read or write; the age saturates at BL/2
  logic [4:0] burst_age_r, burst_age_nxt;
  logic [4:0] eff_bl_r, eff_bl_nxt;
  always_comb begin
    burst_age_nxt = (burst_age_r < 5'(HALF_BL)) ? burst_age_r + 5'h1 : burst_age_r;
    eff_bl_nxt = eff_bl_r;
    if (is_rd || is_wr) begin
      burst_age_nxt = 5'h1;
      eff_bl_nxt = 5'(BL);
    end else if (is_bst) begin
      eff_bl_nxt = {burst_age_r[3:0], 1'b0};
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      burst_age_r <= 5'h0;
      eff_bl_r <= 5'(BL);
    end else begin
      burst_age_r <= burst_age_nxt;
      eff_bl_r <= eff_bl_nxt;
    end
  end
  assign o_eff_burst_len = eff_bl_r;

  ////////////////////////////////////////////////////////////////////////////
  // helper counters for bank 0, read only by the checks below
  // they saturate, so a long quiet stretch never wraps into a false match
  logic [7:0] ap_age0_r, ap_age0_nxt, rp_age0_r, rp_age0_nxt;
  logic ap_src0_r, ap_src0_nxt, ap_wr0_r, ap_wr0_nxt;
  logic pre_hit0, ap_hit0;
  assign pre_hit0 = (is_pre && i_bank == 3'h0) || is_pre_all;
  assign ap_hit0 = (is_rd || is_wr) && i_ap_bit && i_bank == 3'h0 && o_bank_open[0];
  always_comb begin
    ap_age0_nxt = (ap_age0_r != 8'hff) ? ap_age0_r + 8'h1 : ap_age0_r;
    rp_age0_nxt = (rp_age0_r != 8'hff) ? rp_age0_r + 8'h1 : rp_age0_r;
    ap_src0_nxt = ap_src0_r;
    ap_wr0_nxt = ap_wr0_r;
    if (ap_hit0) begin
      ap_age0_nxt = 8'h1;
      ap_src0_nxt = 1'b1;
      ap_wr0_nxt = is_wr;
    end
    // an explicit precharge takes over the timing from any pending auto precharge
    if (pre_hit0) begin
      rp_age0_nxt = 8'h1;
      ap_src0_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ap_age0_r <= 8'h0;
      rp_age0_r <= 8'h0;
      ap_src0_r <= 1'b0;
      ap_wr0_r <= 1'b0;
    end else begin
      ap_age0_r <= ap_age0_nxt;
      rp_age0_r <= rp_age0_nxt;
      ap_src0_r <= ap_src0_nxt;
      ap_wr0_r <= ap_wr0_nxt;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  rd_ap_engage_a: assert property (
    (is_rd && i_ap_bit && o_bank_open[i_bank]) |=> o_ap_pending[$past(i_bank)])
    else $error("read with bit set did not engage auto precharge");

  wr_ap_engage_a: assert property (
    (is_wr && i_ap_bit && o_bank_open[i_bank]) |=> o_ap_pending[$past(i_bank)])
    else $error("write with bit set did not engage auto precharge");

  pend_no_reopen_a: assert property (
    o_ap_pending[0] |=> !o_bank_open[0])
    else $error("bank with pending auto precharge reopened");

  rd_plain_open_a: assert property (
    (is_rd && !i_ap_bit && o_bank_open[i_bank] && !is_pre_all) |=> o_bank_open[$past(i_bank)])
    else $error("plain read closed the bank");

  // the age is read one edge after the precharge began, hence the extra cycle
  ap_start_time_a: assert property (
    ($rose(o_precharging[0]) && ap_src0_r && !$past(pre_hit0))
      |-> (ap_age0_r == (ap_wr0_r ? 8'(WR_AP_CYC + 1) : 8'(RD_AP_CYC + 1))))
    else $error("auto precharge began at the wrong edge");

  pre_restart_a: assert property (
    pre_hit0 |=> o_precharging[0] && rp_age0_r == 8'h1)
    else $error("precharge did not restart the period");

  pre_idle_time_a: assert property (
    ($rose(o_bank_idle[0]) && !ap_src0_r) |-> (rp_age0_r == 8'(dram_ap_pkg::RP_PB_CYC + 1)
      || rp_age0_r == 8'(dram_ap_pkg::RP_AB_CYC + 1)))
    else $error("bank went idle before tRP elapsed");

  array_group_a: assert property (
    o_array_write |-> $past(i_wr_word_valid) && $past(grp_cnt_r) == 2'h3 && !$past(is_wr))
    else $error("array write without a whole group");

  seamless_rd_a: assert property (
    (is_rd && i_ap_bit && i_bank == 3'h0 && o_bank_open[0]) ##HALF_BL
    (is_rd && i_ap_bit && i_bank == 3'h1 && o_bank_open[1]) |=> o_ap_pending[1] && !o_bank_open[0])
    else $error("gapless read to another bank was lost");

  eff_bl_a: assert property (
    (is_bst && !is_rd && !is_wr) |=> o_eff_burst_len == {$past(burst_age_r[3:0]), 1'b0})
    else $error("effective burst length wrong after burst terminate");

  rd_ap_cov: cover property (is_rd && i_ap_bit && o_bank_open[i_bank] ##[1:40] o_bank_idle[0]);
  wr_ap_cov: cover property (is_wr && i_ap_bit && o_bank_open[i_bank] ##1 o_ap_pending[$past(i_bank)]);
  pre_all_cov: cover property (is_pre_all ##1 (&o_precharging));
  bst_cov: cover property (is_rd ##2 is_bst);
  grp_cov: cover property (i_wr_word_valid ##1 o_array_write);
endmodule : dram_auto_precharge_timing
`default_nettype wire

/* File: verif/ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ctrl_model #(
  parameter int WL = dram_ap_pkg::DEF_WL,
  parameter int BL = dram_ap_pkg::DEF_BL,
  // read latency, strobe skew and write-to-read turnaround are plain defaults for this model
  parameter int RL = 6,
  parameter int DQSCK_CYC = 1,
  parameter int WTR_CYC = 2
) (
  input wire logic i_core_clk,
  output logic o_cmd_valid,
  output logic [2:0] o_cmd,
  output logic [2:0] o_bank,
  output logic o_ap_bit,
  output logic o_wr_word_valid
);
  localparam int RP = dram_ap_pkg::RP_PB_CYC;
  localparam int RTP = dram_ap_pkg::RTP_CYC > 2 ? dram_ap_pkg::RTP_CYC : 2;
  int cyc = 0;
  int ready_at [8] = '{default: 0};
  int pre_at [8] = '{default: 0};
  int pre_all_at = 0;
  int rd_at = 0;
  int wr_at = 0;
  logic [2:0] last_b = 3'h0;
  logic last_wr = 1'b0;
  // a precharge-all must wait for the slowest bank, so it tracks the maximum
  function automatic void hold_pre(input logic [2:0] b, input int at);
    pre_at[b] = at;
    if (at > pre_all_at) pre_all_at = at;
  endfunction : hold_pre
  always @(posedge i_core_clk) cyc <= cyc + 1;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = 3'h0;
    o_bank = 3'h0;
    o_ap_bit = 1'b0;
    o_wr_word_valid = 1'b0;
  end
  //////////////////////////////////////////
  // activate waits until the bank has closed again after an auto precharge
  task automatic issue(input dram_ap_pkg::cmd_e c, input logic [2:0] b, input logic ap);
    @(posedge i_core_clk);
    while ((c == dram_ap_pkg::CMD_ACT && cyc < ready_at[b]) || (c == dram_ap_pkg::CMD_PRE && cyc < pre_at[b])
        || (c == dram_ap_pkg::CMD_PRE_ALL && cyc < pre_all_at) || (c == dram_ap_pkg::CMD_RD && cyc < rd_at)
        || (c == dram_ap_pkg::CMD_WR && cyc < wr_at)) @(posedge i_core_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    o_bank <= b;
    o_ap_bit <= ap;
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b0;
    // released lines flip, so a stale value can decode as another command and only o_cmd_valid marks a real one
    o_cmd <= ~c;
    o_bank <= ~b;
    o_ap_bit <= ~ap;
    if (c == dram_ap_pkg::CMD_RD && ap) ready_at[b] = cyc + BL / 2 + RTP - 2 + RP;
    if (c == dram_ap_pkg::CMD_WR && ap) ready_at[b] = cyc + WL + BL / 2 + dram_ap_pkg::WR_CYC + 1 + RP;
    if (c == dram_ap_pkg::CMD_RD) hold_pre(b, cyc + BL / 2 + RTP - 2);
    if (c == dram_ap_pkg::CMD_WR) hold_pre(b, cyc + WL + BL / 2 + 1 + dram_ap_pkg::WR_CYC);
    if (c == dram_ap_pkg::CMD_BURST_TERM) begin
      hold_pre(last_b, cyc + (last_wr ? WL + dram_ap_pkg::WR_CYC + 1 : 1));
    end
    if (c == dram_ap_pkg::CMD_RD && ap) wr_at = cyc + RL + BL / 2 + DQSCK_CYC - WL + 1;
    if (c == dram_ap_pkg::CMD_WR && ap) rd_at = cyc + WL + BL / 2 + WTR_CYC + 1;
    if (c == dram_ap_pkg::CMD_RD || c == dram_ap_pkg::CMD_WR) begin
      last_b = b;
      last_wr = (c == dram_ap_pkg::CMD_WR);
    end
  endtask : issue
  task automatic words(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      o_wr_word_valid <= 1'b1;
    end
    @(posedge i_core_clk);
    o_wr_word_valid <= 1'b0;
  endtask : words
endmodule : ctrl_model
`default_nettype wire

/* File: verif/dram_auto_precharge_timing_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module dram_auto_precharge_timing_bench;
  localparam logic [7:0] s_idle = 8'h08;
  localparam logic [7:0] s_open = 8'h04;
  localparam logic [7:0] s_pend = 8'h02;
  localparam logic [7:0] s_pre = 8'h01;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic cmd_valid, ap_bit, word_valid, array_write;
  logic [2:0] cmd, bank;
  logic [7:0] bank_idle, bank_open, ap_pend, prech;
  logic [4:0] eff_len;
  int errors = 0;
  int n_checks = 0;
  initial begin
    forever #4 i_core_clk = ~i_core_clk;
  end
  ctrl_model model (.i_core_clk(i_core_clk), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_bank(bank),
    .o_ap_bit(ap_bit), .o_wr_word_valid(word_valid));
  dram_auto_precharge_timing dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_bank(bank), .i_ap_bit(ap_bit), .i_wr_word_valid(word_valid), .o_bank_idle(bank_idle),
    .o_bank_open(bank_open), .o_ap_pending(ap_pend), .o_precharging(prech), .o_array_write(array_write),
    .o_eff_burst_len(eff_len));
  //////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] st(input int b);
    return {4'h0, bank_idle[b], bank_open[b], ap_pend[b], prech[b]};
  endfunction : st
  task automatic trace(input int b, input int np, input int nr);
    repeat (np) begin
      @(negedge i_core_clk);
      check(st(b), s_pend);
    end
    repeat (nr) begin
      @(negedge i_core_clk);
      check(st(b), s_pre);
    end
    @(negedge i_core_clk);
    check(st(b), s_idle);
  endtask : trace
  task automatic rd_ap_seamless;
    model.issue(dram_ap_pkg::CMD_ACT, 3'h0, 1'b0);
    model.issue(dram_ap_pkg::CMD_ACT, 3'h1, 1'b0);
    @(negedge i_core_clk);
    check(st(1), s_open);
    model.issue(dram_ap_pkg::CMD_RD, 3'h0, 1'b1);
    repeat (2) @(posedge i_core_clk);
    model.issue(dram_ap_pkg::CMD_RD, 3'h1, 1'b1);
    @(negedge i_core_clk);
    check(st(0), s_pre);
    check(st(1), s_pend);
    trace(1, 3, 3);
    check(st(0), s_idle);
  endtask : rd_ap_seamless
  task automatic pre_restart;
    model.issue(dram_ap_pkg::CMD_ACT, 3'h1, 1'b0);
    model.issue(dram_ap_pkg::CMD_RD, 3'h1, 1'b0);
    repeat (10) @(negedge i_core_clk);
    check(st(1), s_open);
    model.issue(dram_ap_pkg::CMD_PRE, 3'h1, 1'b0);
    @(negedge i_core_clk);
    check(st(1), s_pre);
    model.issue(dram_ap_pkg::CMD_PRE_ALL, 3'h0, 1'b0);
    trace(1, 0, 3);
    check(bank_idle, 8'hff);
  endtask : pre_restart
  task automatic wr_ap;
    model.issue(dram_ap_pkg::CMD_ACT, 3'h0, 1'b0);
    model.issue(dram_ap_pkg::CMD_WR, 3'h0, 1'b1);
    trace(0, 11, 3);
  endtask : wr_ap
  task automatic word_groups;
    model.words(3);
    @(negedge i_core_clk);
    check({7'h0, array_write}, 8'h00);
    model.words(1);
    @(negedge i_core_clk);
    check({7'h0, array_write}, 8'h01);
    @(negedge i_core_clk);
    check({7'h0, array_write}, 8'h00);
    model.issue(dram_ap_pkg::CMD_ACT, 3'h3, 1'b0);
    model.words(2);
    // a new write drops the half group
    model.issue(dram_ap_pkg::CMD_WR, 3'h3, 1'b0);
    model.words(2);
    @(negedge i_core_clk);
    check({7'h0, array_write}, 8'h00);
    model.words(2);
    @(negedge i_core_clk);
    check({7'h0, array_write}, 8'h01);
  endtask : word_groups
  task automatic burst_trunc;
    model.issue(dram_ap_pkg::CMD_RD, 3'h3, 1'b0);
    model.issue(dram_ap_pkg::CMD_BURST_TERM, 3'h3, 1'b0);
    @(negedge i_core_clk);
    check({3'h0, eff_len}, 8'h04);
    model.issue(dram_ap_pkg::CMD_WR, 3'h3, 1'b0);
    @(negedge i_core_clk);
    check({3'h0, eff_len}, 8'(dram_ap_pkg::DEF_BL));
    check(st(3), s_open);
  endtask : burst_trunc
  //////////////////////////////////////////
  task automatic complete_run;
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(negedge i_core_clk);
    check(bank_idle, 8'hff);
    check(bank_open | ap_pend | prech, 8'h00);
    check({3'h0, eff_len}, 8'(dram_ap_pkg::DEF_BL));
    rd_ap_seamless();
    pre_restart();
    wr_ap();
    word_groups();
    burst_trunc();
    complete_run();
  end
  // the whole run takes well under a thousand cycles
  initial begin
    #20000;
    errors++;
    complete_run();
  end
endmodule : dram_auto_precharge_timing_bench
`default_nettype wire
